//--- core/uet_pkg.sv
// constants and types shared by the serial transmit port
package uet_pkg;
	// apb byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_TXW = 8'h08;
	localparam logic [7:0] OFS_BRG = 8'h0c;
	// mode_control_register fields
	localparam int MB_EN = 15;
	localparam int MB_ALT = 10;
	localparam int MB_FMT = 1;
	localparam int MB_STOP = 0;
	// status_control_register fields
	localparam int SB_TXISEL = 15;
	localparam int SB_BRK = 11;
	localparam int SB_TXEN = 10;
	localparam int SB_TXBF = 9;
	localparam int SB_SHIFTER_EMPTY_FLAG = 8;
	localparam int SB_RXISEL = 6;
	localparam int SB_ADDRESS_DETECT_ENABLE = 5;
	localparam int SB_RECEIVER_IDLE_FLAG = 4;
	// frame formats
	typedef enum logic [1:0] {
		UET_F8N = 2'h0,
		UET_F8E = 2'h1,
		UET_F8O = 2'h2,
		UET_F9N = 2'h3
	} uet_fmt_t;
	// sizes
	localparam int DATA_W = 9;
	localparam int DEPTH = 4;
	localparam int FRAME_W = 13;
	// reset values
	localparam logic [1:0] RST_FMT = 2'h0;
	localparam logic RST_STOP = 1'b0;
	localparam logic [15:0] RST_BRG = 16'h0000;
	// shift counts: start, 8 data, 1 stop, plus one settle step
	localparam logic [3:0] NB_BASE = 4'hb;
	// pin slots in the pin vectors
	localparam logic [3:0] PIN_TX = 4'h1;
	localparam logic [3:0] PIN_RX = 4'h2;
	localparam logic [3:0] PIN_ATX = 4'h4;
	localparam logic [3:0] PIN_ARX = 4'h8;
endpackage

//--- core/uet_txfifo.sv
// four-entry nine-bit transmit fifo
`timescale 1ns/1ps
`default_nettype none
module uet_txfifo (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic flush,
	input wire logic push,
	input wire logic [8:0] push_data,
	input wire logic pop,
	// status
	output logic [8:0] head,
	output logic full,
	output logic empty,
	output logic [2:0] count
);
	typedef struct packed {
		logic [3:0][8:0] mem;
		logic [1:0] wp;
		logic [1:0] rp;
		logic [2:0] cnt;
	} uet_fifo_t;
	uet_fifo_t q, d;

	// status from pointers and count
	assign full = (q.cnt == 3'(uet_pkg::DEPTH));
	assign empty = (q.cnt == 3'h0);
	assign count = q.cnt;
	assign head = q.mem[q.rp];

	// next state; a push into a full fifo is dropped untouched
	always_comb begin
		d = q;
		if (flush) begin
			d.wp = 2'h0;
			d.rp = 2'h0;
			d.cnt = 3'h0;
		end else begin
			if (push && !full) begin
				d.mem[q.wp] = push_data;
				d.wp = q.wp + 2'h1;
			end
			if (pop && !empty) begin
				d.rp = q.rp + 2'h1;
			end
			d.cnt = q.cnt + 3'(push && !full) - 3'(pop && !empty);
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // uet_txfifo
`default_nettype wire

//--- core/uet_top.sv
// serial port enable, frame format and transmit path with apb registers
// Functional notes
// - enabled: out pin drives, in pin input
// - idle serial line stays high
// - reset disables; pins become port pins
// - disable empties buffers, resets baud counter
// - disable clears flags, sets idle flags
// - disable keeps selects, mode, divisor
// - disable aborts; re-enable keeps configuration
// - alternate select swaps to alternate pins
// - format field picks four frame formats
// - stop select: one or two stops
// - reset format eight bits, none, one
// - free shifter loads at once, ticks next
// - data queued before transmit enable starts immediately
// - four-deep buffer with full flag
// - write to full buffer is dropped
// - any reset empties transmit fifo
// - irq edge per transfer or emptied
// - break request forces line low
// - break causes no transmit irq
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module uet_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port latch and direction, order alt_rx alt_tx rx tx
	input wire logic [3:0] port_lat,
	input wire logic [3:0] port_oe,
	// pad drive, same order
	output logic [3:0] pin_o,
	output logic [3:0] pin_oe,
	// transmit interrupt edge
	output logic transmit_irq_flag
);
	typedef struct packed {
		logic en;
		logic alternate_pin_select;
		logic [1:0] fmt;
		logic stop_count_select;
		logic txisel;
		logic brk;
		logic txen;
		logic address_detect_enable;
		logic [1:0] rxisel;
		logic [15:0] brg;
		logic [15:0] bcnt;
		logic fresh;
		logic [12:0] sh;
		logic [3:0] cnt;
		logic line;
		logic irq;
		logic [31:0] rdata;
	} uet_st_t;
	uet_st_t q, d;

	logic wr;
	logic rd_setup;
	logic tick;
	logic load;
	logic push;
	logic flush;
	logic f_full;
	logic f_empty;
	logic [2:0] f_count;
	logic [8:0] f_head;
	logic [12:0] frame;
	logic [3:0] nbits;
	logic tx_line;
	logic [3:0] own;
	logic [3:0] txsel;
	logic shifter_empty_flag;

	// apb strobes; every access completes in its first access cycle
	assign wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = q.rdata;
	assign shifter_empty_flag = (q.cnt == 4'h0);
	assign push = wr && (paddr == uet_pkg::OFS_TXW) && q.en;
	assign flush = !d.en;

	// transmit buffer
	// four by nine
	uet_txfifo u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.flush(flush),
		.push(push),
		.push_data(pwdata[8:0]),
		.pop(load),
		.head(f_head),
		.full(f_full),
		.empty(f_empty),
		.count(f_count)
	);

	// baud tick; a fresh start ticks at once, otherwise a tick comes when the counter reaches brg
	// fresh start ticks
	assign tick = q.en && q.txen && (q.fresh || (q.bcnt == q.brg));
	// shifter takes a word whenever it is free, the transmitter is on and no break is set
	// immediate load
	assign load = q.en && q.txen && !q.brk && shifter_empty_flag && !f_empty;

	// frame image, shifted out lsb first, padded with ones
	// format choice
	always_comb begin
		case (uet_pkg::uet_fmt_t'(q.fmt))
			uet_pkg::UET_F8N: begin
				frame = {4'hf, f_head[7:0], 1'b0};
				nbits = uet_pkg::NB_BASE;
			end
			uet_pkg::UET_F8E: begin
				frame = {3'h7, ^f_head[7:0], f_head[7:0], 1'b0};
				nbits = uet_pkg::NB_BASE + 4'h1;
			end
			uet_pkg::UET_F8O: begin
				frame = {3'h7, ~^f_head[7:0], f_head[7:0], 1'b0};
				nbits = uet_pkg::NB_BASE + 4'h1;
			end
			default: begin
				frame = {3'h7, f_head, 1'b0};
				nbits = uet_pkg::NB_BASE + 4'h1;
			end
		endcase
	end

	// next state
	always_comb begin
		d = q;
		d.irq = 1'b0;
		// register writes
		if (wr) begin
			case (paddr)
				uet_pkg::OFS_MODE: begin
					d.en = pwdata[uet_pkg::MB_EN];
					d.alternate_pin_select = pwdata[uet_pkg::MB_ALT];
					d.fmt = pwdata[uet_pkg::MB_FMT +: 2];
					d.stop_count_select = pwdata[uet_pkg::MB_STOP];
				end
				uet_pkg::OFS_STAT: begin
					d.txisel = pwdata[uet_pkg::SB_TXISEL];
					d.brk = pwdata[uet_pkg::SB_BRK];
					d.txen = pwdata[uet_pkg::SB_TXEN] && q.en;
					d.rxisel = pwdata[uet_pkg::SB_RXISEL +: 2];
					d.address_detect_enable = pwdata[uet_pkg::SB_ADDRESS_DETECT_ENABLE];
				end
				uet_pkg::OFS_BRG: begin
					d.brg = pwdata[15:0];
				end
				default: begin
				end
			endcase
		end
		// read data captured in the setup cycle
		if (rd_setup) begin
			case (paddr)
				uet_pkg::OFS_MODE: begin
					d.rdata = '0;
					d.rdata[uet_pkg::MB_EN] = q.en;
					d.rdata[uet_pkg::MB_ALT] = q.alternate_pin_select;
					d.rdata[uet_pkg::MB_FMT +: 2] = q.fmt;
					d.rdata[uet_pkg::MB_STOP] = q.stop_count_select;
				end
				uet_pkg::OFS_STAT: begin
					d.rdata = '0;
					d.rdata[uet_pkg::SB_TXISEL] = q.txisel;
					d.rdata[uet_pkg::SB_BRK] = q.brk;
					d.rdata[uet_pkg::SB_TXEN] = q.txen;
					d.rdata[uet_pkg::SB_TXBF] = f_full;
					d.rdata[uet_pkg::SB_SHIFTER_EMPTY_FLAG] = shifter_empty_flag;
					d.rdata[uet_pkg::SB_RXISEL +: 2] = q.rxisel;
					d.rdata[uet_pkg::SB_ADDRESS_DETECT_ENABLE] = q.address_detect_enable;
					d.rdata[uet_pkg::SB_RECEIVER_IDLE_FLAG] = 1'b1;
				end
				uet_pkg::OFS_BRG: begin
					d.rdata = {16'h0000, q.brg};
				end
				default: begin
					d.rdata = '0;
				end
			endcase
		end
		// baud counter
		if (tick) begin
			d.bcnt = 16'h0000;
		end else if (q.en && q.txen) begin
			d.bcnt = q.bcnt + 16'h0001;
		end
		// shifting one bit per tick
		if (tick && (q.cnt != 4'h0)) begin
			d.line = q.sh[0];
			d.sh = {1'b1, q.sh[12:1]};
			d.cnt = q.cnt - 4'h1;
			d.fresh = 1'b0;
		end
		if (load) begin
			d.sh = frame;
			d.cnt = nbits + 4'(q.stop_count_select);
			d.irq = !q.txisel || ((f_count == 3'h1) && !push);
		end
		// transmitter off holds the baud clock cleared
		if (!d.txen) begin
			d.bcnt = 16'h0000;
			d.fresh = 1'b1;
		end
		// disable side effects; configuration stays
		// flags on disable
		if (!d.en) begin
			d.txen = 1'b0;
			d.brk = 1'b0;
			d.cnt = 4'h0;
			d.sh = '1;
			d.line = 1'b1;
			d.bcnt = 16'h0000;
			d.fresh = 1'b1;
		end
	end

	// state register
	// reset disables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.fmt <= uet_pkg::RST_FMT;
			q.stop_count_select <= uet_pkg::RST_STOP;
			q.brg <= uet_pkg::RST_BRG;
			q.sh <= '1;
			q.line <= 1'b1;
			q.fresh <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// line level; break wins over everything
	// break low
	assign tx_line = q.brk ? 1'b0 : q.line;
	assign transmit_irq_flag = q.irq;

	// pin ownership
	// alternate pins
	assign txsel = q.alternate_pin_select ? uet_pkg::PIN_ATX : uet_pkg::PIN_TX;
	assign own = q.en ? (q.alternate_pin_select ? (uet_pkg::PIN_ATX | uet_pkg::PIN_ARX)
		: (uet_pkg::PIN_TX | uet_pkg::PIN_RX)) : 4'h0;
	assign pin_oe = (port_oe & ~own) | (txsel & {4{q.en}});
	assign pin_o = (port_lat & ~own) | (txsel & {4{q.en && tx_line}});

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_idle_high;
		q.en && !q.brk && shifter_empty_flag |-> (pin_o & txsel) == txsel;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("idle line not high");

	property p_break_low;
		q.brk && q.en |-> ((pin_o & txsel) == 4'h0) && ((pin_oe & txsel) == txsel);
	endproperty
	a_break_low: assert property (p_break_low)
		else $error("break not driving low");

	property p_port_mode;
		!q.en |-> (pin_o == port_lat) && (pin_oe == port_oe);
	endproperty
	a_port_mode: assert property (p_port_mode)
		else $error("disabled pins not port pins");

	property p_disable;
		$fell(q.en) |-> !q.txen && !q.brk && f_empty && shifter_empty_flag && q.bcnt == 16'h0000;
	endproperty
	a_disable: assert property (p_disable)
		else $error("disable did not reset state");

	property p_keep_cfg;
		$fell(q.en) |-> $stable(q.brg) && $stable(q.txisel) && $stable(q.rxisel) && $stable(q.address_detect_enable);
	endproperty
	a_keep_cfg: assert property (p_keep_cfg)
		else $error("disable changed configuration");

	property p_full_drop;
		f_full && push && !load |=> f_full && f_count == 3'h4;
	endproperty
	a_full_drop: assert property (p_full_drop)
		else $error("write into full buffer changed it");

	property p_irq;
		load && (!q.txisel || (f_count == 3'h1 && !push)) |=> transmit_irq_flag;
	endproperty
	a_irq: assert property (p_irq)
		else $error("transmit irq missing");

	property p_irq_cause;
		transmit_irq_flag |-> $past(load) && !$past(q.brk);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("irq without transfer");

	property p_start_bit;
		load && q.fresh ##1 tick |=> q.line == 1'b0;
	endproperty
	a_start_bit: assert property (p_start_bit)
		else $error("start bit not immediate");

	property p_alt;
		q.en |-> (q.alternate_pin_select ? (pin_oe[3:2] == 2'h1 && pin_oe[1:0] == port_oe[1:0])
			: (pin_oe[1:0] == 2'h1 && pin_oe[3:2] == port_oe[3:2]));
	endproperty
	a_alt: assert property (p_alt)
		else $error("wrong pin pair in use");

	c_load: cover property (load ##1 q.cnt != 4'h0);
	c_full: cover property (f_full && push);
	c_break: cover property (q.brk && q.en);
	c_disable: cover property ($fell(q.en) && !$past(shifter_empty_flag));
endmodule // uet_top
`default_nettype wire

//--- tb/uet_rx_model.sv
// behavioural serial receiver on the transmit line
`timescale 1ns/1ps
`default_nettype none
module uet_rx_model #(
	parameter int BIT_CYC = 4
) (
	// clock and line
	input wire logic pclk,
	input wire logic line,
	// frame length in bits
	input wire logic [3:0] nbits,
	// last frame, first bit in bit 0
	output logic [15:0] frame,
	output int frames
);
	// waits for idle, then a falling start edge
	initial begin
		frame = 16'h0000;
		frames = 0;
		forever begin
			@(posedge pclk iff line === 1'b1);
			@(posedge pclk iff line === 1'b0);
			frame = 16'h0000;
			repeat (BIT_CYC / 2) @(posedge pclk);
			for (int i = 0; i < nbits; i++) begin
				frame[i] = line;
				if (i < nbits - 1) repeat (BIT_CYC) @(posedge pclk);
			end
			frames++;
		end
	end
endmodule // uet_rx_model
`default_nettype wire

//--- tb/tb_uet_top.sv
// self-checking bench for the serial transmit port
`timescale 1ns/1ps
`default_nettype none
module tb_uet_top;
	typedef struct {
		logic [31:0] mode;
		logic [31:0] data;
		logic [3:0] len;
		logic [31:0] exp;
	} uet_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, alt, line, slverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] port_lat, port_oe, pin_o, pin_oe, nbits;
	logic [15:0] frame;
	int frames, fail_count, tests_run, irq_n, f0, g0;
	// format rows: mode word, data, frame length, frame bits
	uet_row_t rows [6] = '{
		'{32'h8000, 32'ha5, 4'ha, 32'h34a},
		'{32'h8003, 32'ha5, 4'hc, 32'hd4a},
		'{32'h8002, 32'h07, 4'hb, 32'h60e},
		'{32'h8004, 32'h07, 4'hb, 32'h40e},
		'{32'h8004, 32'h01, 4'hb, 32'h402},
		'{32'h8007, 32'h155, 4'hc, 32'heaa}};
	uet_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_lat(port_lat), .port_oe(port_oe),
		.pin_o(pin_o), .pin_oe(pin_oe), .transmit_irq_flag(irq));
	// receiver watches the selected transmit pin
	assign line = alt ? pin_o[2] : pin_o[0];
	uet_rx_model #(.BIT_CYC(4)) rx (.pclk(pclk), .line(line), .nbits(nbits),
		.frame(frame), .frames(frames));
	// count interrupt pulses
	always @(posedge pclk) if (irq === 1'b1) irq_n++;
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wait_fr(input int n);
		repeat (2000) if (frames < n) @(posedge pclk);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (6000) @(posedge pclk);
		fail_count++;
		complete_run();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		port_lat = 4'h5;
		port_oe = 4'ha;
		alt = 1'b0;
		nbits = 4'ha;
		fail_count = 0;
		tests_run = 0;
		irq_n = 0;
		repeat (2) @(posedge pclk);
		cmp("pin_oe", 32'ha, pin_oe);
		presetn <= 1'b1;
		@(posedge pclk);
		cmp("pin_o", 32'h5, pin_o);
		apb(1'b0, uet_pkg::OFS_MODE, 32'h0);
		cmp("mode", 32'h0, rd);
		apb(1'b0, uet_pkg::OFS_STAT, 32'h0);
		cmp("status", 32'h110, rd);
		apb(1'b0, 8'h10, 32'h0);
		cmp("unmapped", 32'h0, rd);
		cmp("pslverr", 32'h0, slverr);
		apb(1'b1, uet_pkg::OFS_BRG, 32'h3);
		apb(1'b1, uet_pkg::OFS_MODE, 32'h8000);
		cmp("oe", 32'h1, pin_oe[1:0]);
		cmp("idle", 32'h1, pin_o[0]);
		apb(1'b1, uet_pkg::OFS_STAT, 32'h400);
		foreach (rows[i]) begin
			nbits <= rows[i].len;
			apb(1'b1, uet_pkg::OFS_MODE, rows[i].mode);
			f0 = frames;
			// nine-bit word has upper bits clear
			apb(1'b1, uet_pkg::OFS_TXW, rows[i].data);
			wait_fr(f0 + 1);
			repeat (8) @(posedge pclk);
			cmp("frame", rows[i].exp, frame);
		end
		cmp("irq", 32'h6, irq_n);
		$display("test formats done");
		nbits <= 4'ha;
		apb(1'b1, uet_pkg::OFS_MODE, 32'h8000);
		apb(1'b1, uet_pkg::OFS_STAT, 32'h8400);
		f0 = frames;
		g0 = irq_n;
		for (int k = 1; k < 7; k++) apb(1'b1, uet_pkg::OFS_TXW, 32'h10 + k);
		apb(1'b0, uet_pkg::OFS_STAT, 32'h0);
		cmp("full", 32'h1, rd[9]);
		wait_fr(f0 + 5);
		repeat (60) @(posedge pclk);
		cmp("frames", 32'h5, frames - f0);
		cmp("last", 32'h22a, frame);
		cmp("irq", 32'h2, irq_n - g0);
		$display("test fifo done");
		g0 = irq_n;
		apb(1'b1, uet_pkg::OFS_STAT, 32'h8c00);
		cmp("brk", 32'h0, pin_o[0]);
		// break held past thirteen bit times
		repeat (56) @(posedge pclk);
		apb(1'b1, uet_pkg::OFS_STAT, 32'h8400);
		repeat (8) @(posedge pclk);
		cmp("stop", 32'h1, pin_o[0]);
		cmp("irq", 32'h0, irq_n - g0);
		$display("test break done");
		apb(1'b1, uet_pkg::OFS_TXW, 32'h5a);
		repeat (10) @(posedge pclk);
		apb(1'b1, uet_pkg::OFS_MODE, 32'h0405);
		cmp("pins", 32'ha5, {pin_oe, pin_o});
		apb(1'b0, uet_pkg::OFS_STAT, 32'h0);
		cmp("status", 32'h8110, rd);
		apb(1'b0, uet_pkg::OFS_MODE, 32'h0);
		cmp("mode", 32'h405, rd);
		apb(1'b0, uet_pkg::OFS_BRG, 32'h0);
		cmp("divisor", 32'h3, rd);
		repeat (40) @(posedge pclk);
		$display("test disable done");
		apb(1'b1, uet_pkg::OFS_MODE, 32'h8400);
		cmp("alt oe", 32'h6, pin_oe);
		cmp("alt idle", 32'h1, pin_o[2]);
		alt <= 1'b1;
		f0 = frames;
		apb(1'b1, uet_pkg::OFS_TXW, 32'h3c);
		apb(1'b1, uet_pkg::OFS_STAT, 32'h400);
		repeat (2) @(posedge pclk);
		cmp("start", 32'h0, pin_o[2]);
		wait_fr(f0 + 1);
		cmp("alt frame", 32'h278, frame);
		$display("test alternate done");
		for (int k = 0; k < 5; k++) apb(1'b1, uet_pkg::OFS_TXW, 32'h40 + k);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, uet_pkg::OFS_STAT, 32'h0);
		cmp("status", 32'h110, rd);
		$display("test reset done");
		complete_run();
	end
endmodule // tb_uet_top
`default_nettype wire
